// *** design/umcls_pkg.sv ***
package umcls_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] UMCLS_IDX_LINE_CTL  = 6'h03;
    localparam logic [5:0] UMCLS_IDX_MODEM_CTL = 6'h04;
    localparam logic [5:0] UMCLS_IDX_LINE_STAT = 6'h05;
    localparam logic [7:0] UMCLS_OFF_MODEM_CTL = {UMCLS_IDX_MODEM_CTL, 2'b00};
    localparam logic [7:0] UMCLS_OFF_LINE_STAT = {UMCLS_IDX_LINE_STAT, 2'b00};
    localparam logic [7:0] UMCLS_OFF_LINE_CTL  = {UMCLS_IDX_LINE_CTL, 2'b00};
    localparam int UMCLS_MC_DTR   = 0;
    localparam int UMCLS_MC_RTS   = 1;
    localparam int UMCLS_MC_AUX1  = 2;
    localparam int UMCLS_MC_AUX2  = 3;
    localparam int UMCLS_MC_LOOP  = 4;
    localparam int UMCLS_MC_AUTO_FLOW = 5;
    localparam int UMCLS_MC_HALF  = 7;
    localparam int UMCLS_LC_BREAK = 6;
    localparam logic [7:0] UMCLS_MC_WMASK = 8'hBF;
    localparam logic [7:0] UMCLS_RST_MODEM_CTL = 8'h00;
    localparam logic [7:0] UMCLS_RST_LINE_CTL  = 8'h00;
    localparam int UMCLS_LS_RXAV  = 0;
    localparam int UMCLS_LS_OVR   = 1;
    localparam int UMCLS_LS_PAR   = 2;
    localparam int UMCLS_LS_FRM   = 3;
    localparam int UMCLS_LS_BRK   = 4;
    localparam int UMCLS_LS_THRE  = 5;
    localparam int UMCLS_LS_TEMT  = 6;
    localparam int UMCLS_LS_FERR  = 7;
endpackage

// *** design/umcls_top.sv ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module umcls_top
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        core_txd,
    output logic             txd,
    input  wire logic        rxd,
    output logic             core_rxd,
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ri_n,
    input  wire logic        dcd_n,
    output logic             dtr_n,
    output logic             rts_n,
    output logic             msr_cts,
    output logic             msr_dsr,
    output logic             msr_ri,
    output logic             msr_dcd,
    input  wire logic        rx_fifo_level_nz,
    input  wire logic        rx_room_low,
    output logic             tx_allowed,
    output logic             diag_mode,
    output logic             half_stop,
    input  wire logic        ev_overrun,
    input  wire logic        ev_parity,
    input  wire logic        ev_framing,
    input  wire logic        ev_break,
    input  wire logic        fifo_has_error,
    input  wire logic        thr_empty,
    input  wire logic        tsr_empty
);
    import umcls_pkg::*;

    logic [7:0] modem_control_reg_ff;
    logic [7:0] line_control_ff;
    logic [3:0] err_ff;
    logic [7:0] line_status;
    logic       rd_access;
    logic       wr_access;
    logic       hit_mc;
    logic       hit_ls;
    logic       hit_lc;
    logic       loopback;
    logic       auto_flow_enable;
    logic       auto_rts;
    logic       auto_cts;
    logic [7:0] nxt_prdata;

    // Zero wait state slave: every access completes in its first access cycle.
    assign pready    = 1'b1;
    assign hit_mc    = (paddr == UMCLS_OFF_MODEM_CTL);
    assign hit_ls    = (paddr == UMCLS_OFF_LINE_STAT);
    assign hit_lc    = (paddr == UMCLS_OFF_LINE_CTL);
    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & penable & ~pwrite;
    // Writes to the read-only status word and unmapped addresses are errors.
    assign pslverr   = psel & penable & ~(hit_mc | hit_lc | (hit_ls & ~pwrite));

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            modem_control_reg_ff <= UMCLS_RST_MODEM_CTL;
        end
        else if (wr_access && hit_mc)
        begin
            modem_control_reg_ff <= pwdata[7:0] & UMCLS_MC_WMASK;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            line_control_ff <= UMCLS_RST_LINE_CTL;
        end
        else if (wr_access && hit_lc)
        begin
            line_control_ff <= pwdata[7:0];
        end
    end

    assign loopback         = modem_control_reg_ff[UMCLS_MC_LOOP];
    assign auto_flow_enable = modem_control_reg_ff[UMCLS_MC_AUTO_FLOW];
    assign auto_rts  = auto_flow_enable & modem_control_reg_ff[UMCLS_MC_RTS];
    assign auto_cts  = auto_flow_enable;
    assign diag_mode = ~auto_flow_enable;
    assign half_stop = modem_control_reg_ff[UMCLS_MC_HALF];

    assign dtr_n = ~modem_control_reg_ff[UMCLS_MC_DTR];
    // Auto RTS asserts RTS while the receive FIFO still has room.
    assign rts_n = auto_rts ? rx_room_low
                            : ~modem_control_reg_ff[UMCLS_MC_RTS];

    // Break wins over data; loopback wins over break so the line stays idle.
    assign txd = loopback ? 1'b1
               : line_control_ff[UMCLS_LC_BREAK] ? 1'b0
               : core_txd;
    // Diagnostic mode also returns transmitted data to the receiver.
    assign core_rxd = (loopback | diag_mode) ? core_txd : rxd;

    assign msr_cts = loopback ? modem_control_reg_ff[UMCLS_MC_RTS]
                              : ~cts_n;
    assign msr_dsr = loopback ? modem_control_reg_ff[UMCLS_MC_DTR]
                              : ~dsr_n;
    assign msr_ri  = loopback ? modem_control_reg_ff[UMCLS_MC_AUX1]
                              : ~ri_n;
    assign msr_dcd = loopback ? modem_control_reg_ff[UMCLS_MC_AUX2]
                              : ~dcd_n;

    // Auto CTS holds transmission off while the partner deasserts CTS.
    assign tx_allowed = ~auto_cts | msr_cts;

    // Error flags are sticky and clear on a line status read; set wins.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            err_ff <= 4'h0;
        end
        else
        begin
            err_ff <= (err_ff & {4{~(rd_access & hit_ls)}})
                    | {ev_break, ev_framing, ev_parity, ev_overrun};
        end
    end

    always_comb
    begin
        line_status                = 8'h00;
        line_status[UMCLS_LS_RXAV] = rx_fifo_level_nz;
        line_status[UMCLS_LS_OVR]  = err_ff[0];
        line_status[UMCLS_LS_PAR]  = err_ff[1];
        line_status[UMCLS_LS_FRM]  = err_ff[2];
        line_status[UMCLS_LS_BRK]  = err_ff[3];
        line_status[UMCLS_LS_THRE] = thr_empty;
        line_status[UMCLS_LS_TEMT] = tsr_empty;
        line_status[UMCLS_LS_FERR] = fifo_has_error;
    end

    always_comb
    begin
        nxt_prdata = 8'h00;
        if (hit_mc)
        begin
            nxt_prdata = modem_control_reg_ff;
        end
        else if (hit_ls)
        begin
            nxt_prdata = line_status;
        end
        else if (hit_lc)
        begin
            nxt_prdata = line_control_ff;
        end
    end
    assign prdata = {24'h000000, nxt_prdata};

    property p_dtr_inv;
        @(posedge clock) disable iff (!rst_n)
        dtr_n == !modem_control_reg_ff[UMCLS_MC_DTR];
    endproperty
    a_dtr_inv: assert property (p_dtr_inv)
        else $error("dtr pin not inverse of control bit");
    property p_rts_manual;
        @(posedge clock) disable iff (!rst_n)
        !auto_flow_enable |-> rts_n == !modem_control_reg_ff[UMCLS_MC_RTS];
    endproperty
    a_rts_manual: assert property (p_rts_manual)
        else $error("rts pin wrong in manual mode");
    property p_loop_ri;
        @(posedge clock) disable iff (!rst_n)
        (wr_access && hit_mc && pwdata[UMCLS_MC_LOOP])
            |=> msr_ri == $past(pwdata[UMCLS_MC_AUX1]);
    endproperty
    a_loop_ri: assert property (p_loop_ri)
        else $error("aux one not looped to ri");
    property p_loop_dcd;
        @(posedge clock) disable iff (!rst_n)
        loopback |-> msr_dcd == modem_control_reg_ff[UMCLS_MC_AUX2];
    endproperty
    a_loop_dcd: assert property (p_loop_dcd)
        else $error("aux two not looped to dcd");
    property p_no_cts_gate;
        @(posedge clock) disable iff (!rst_n)
        !auto_flow_enable |-> tx_allowed;
    endproperty
    a_no_cts_gate: assert property (p_no_cts_gate)
        else $error("cts gating active with flow control off");
    property p_loop_idle;
        @(posedge clock) disable iff (!rst_n) loopback |-> txd;
    endproperty
    a_loop_idle: assert property (p_loop_idle)
        else $error("serial out not idle in loopback");
    property p_break;
        @(posedge clock) disable iff (!rst_n)
        (line_control_ff[UMCLS_LC_BREAK] && !loopback) |-> !txd;
    endproperty
    a_break: assert property (p_break)
        else $error("break not forcing space");
    sequence s_overrun_seen;
        ev_overrun;
    endsequence
    property p_overrun_sticky;
        @(posedge clock) disable iff (!rst_n)
        s_overrun_seen |=> line_status[UMCLS_LS_OVR];
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky)
        else $error("overrun flag lost");
    property p_rxav;
        @(posedge clock) disable iff (!rst_n)
        line_status[UMCLS_LS_RXAV] == rx_fifo_level_nz;
    endproperty
    a_rxav: assert property (p_rxav)
        else $error("data available wrong");

    // Reset checks run without a disable so that the reset edge is seen.
    property p_mc_reset;
        @(posedge clock)
        !rst_n |=> modem_control_reg_ff == UMCLS_RST_MODEM_CTL;
    endproperty
    a_mc_reset: assert property (p_mc_reset)
        else $error("modem control not cleared by reset");

    property p_err_reset;
        @(posedge clock) !rst_n |=> err_ff == 4'h0;
    endproperty
    a_err_reset: assert property (p_err_reset)
        else $error("error flags not cleared by reset");

    sequence s_mc_write;
        wr_access && hit_mc;
    endsequence
    property p_mc_write;
        @(posedge clock) disable iff (!rst_n)
        s_mc_write |=> modem_control_reg_ff
                       == ($past(pwdata[7:0]) & UMCLS_MC_WMASK);
    endproperty
    a_mc_write: assert property (p_mc_write)
        else $error("modem control write lost");

    property p_lc_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_access && hit_lc) |=> line_control_ff == $past(pwdata[7:0]);
    endproperty
    a_lc_write: assert property (p_lc_write)
        else $error("line control write lost");

    property p_loop_handshake;
        @(posedge clock) disable iff (!rst_n)
        loopback |-> msr_cts == modem_control_reg_ff[UMCLS_MC_RTS]
                  && msr_dsr == modem_control_reg_ff[UMCLS_MC_DTR];
    endproperty
    a_loop_handshake: assert property (p_loop_handshake)
        else $error("handshake controls not looped inward");

    property p_loop_ri_hold;
        @(posedge clock) disable iff (!rst_n)
        loopback |-> msr_ri == modem_control_reg_ff[UMCLS_MC_AUX1];
    endproperty
    a_loop_ri_hold: assert property (p_loop_ri_hold)
        else $error("aux one not held on ri");

    property p_pins_inward;
        @(posedge clock) disable iff (!rst_n)
        !loopback |-> msr_cts == !cts_n && msr_dsr == !dsr_n
                   && msr_ri == !ri_n && msr_dcd == !dcd_n;
    endproperty
    a_pins_inward: assert property (p_pins_inward)
        else $error("modem inputs not taken from pins");

    property p_rx_return;
        @(posedge clock) disable iff (!rst_n)
        (loopback || !auto_flow_enable) |-> core_rxd == core_txd;
    endproperty
    a_rx_return: assert property (p_rx_return)
        else $error("transmitted data not returned to receiver");

    property p_rx_pin;
        @(posedge clock) disable iff (!rst_n)
        (!loopback && auto_flow_enable) |-> core_rxd == rxd;
    endproperty
    a_rx_pin: assert property (p_rx_pin)
        else $error("receiver not fed from the pin");

    property p_diag;
        @(posedge clock) disable iff (!rst_n)
        diag_mode == !auto_flow_enable;
    endproperty
    a_diag: assert property (p_diag)
        else $error("diagnostic mode flag wrong");

    property p_auto_rts;
        @(posedge clock) disable iff (!rst_n)
        (auto_flow_enable && modem_control_reg_ff[UMCLS_MC_RTS])
            |-> rts_n == rx_room_low;
    endproperty
    a_auto_rts: assert property (p_auto_rts)
        else $error("auto rts not following receive room");

    property p_cts_only;
        @(posedge clock) disable iff (!rst_n)
        (auto_flow_enable && !modem_control_reg_ff[UMCLS_MC_RTS]) |-> rts_n;
    endproperty
    a_cts_only: assert property (p_cts_only)
        else $error("rts asserted with only auto cts enabled");

    property p_cts_gate;
        @(posedge clock) disable iff (!rst_n)
        auto_flow_enable |-> tx_allowed == msr_cts;
    endproperty
    a_cts_gate: assert property (p_cts_gate)
        else $error("auto cts not gating transmission");

    property p_half_stop;
        @(posedge clock) disable iff (!rst_n)
        half_stop == modem_control_reg_ff[UMCLS_MC_HALF];
    endproperty
    a_half_stop: assert property (p_half_stop)
        else $error("half stop output wrong");

    property p_tx_pass;
        @(posedge clock) disable iff (!rst_n)
        (!loopback && !line_control_ff[UMCLS_LC_BREAK]) |-> txd == core_txd;
    endproperty
    a_tx_pass: assert property (p_tx_pass)
        else $error("serial output not passing core data");

    // A status read clears only flags whose event is absent that cycle.
    sequence s_status_read;
        rd_access && hit_ls;
    endsequence
    sequence s_no_event;
        !ev_overrun && !ev_parity && !ev_framing && !ev_break;
    endsequence
    property p_err_clear;
        @(posedge clock) disable iff (!rst_n)
        s_status_read ##0 s_no_event |=> err_ff == 4'h0;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error flags not cleared by status read");

    property p_err_hold;
        @(posedge clock) disable iff (!rst_n)
        !(rd_access && hit_ls) |=> (err_ff & $past(err_ff)) == $past(err_ff);
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error flag dropped without a read");

    property p_parity_set;
        @(posedge clock) disable iff (!rst_n)
        ev_parity |=> line_status[UMCLS_LS_PAR];
    endproperty
    a_parity_set: assert property (p_parity_set)
        else $error("parity flag lost");

    property p_framing_set;
        @(posedge clock) disable iff (!rst_n)
        ev_framing |=> line_status[UMCLS_LS_FRM];
    endproperty
    a_framing_set: assert property (p_framing_set)
        else $error("framing flag lost");

    property p_break_set;
        @(posedge clock) disable iff (!rst_n)
        ev_break |=> line_status[UMCLS_LS_BRK];
    endproperty
    a_break_set: assert property (p_break_set)
        else $error("break flag lost");

    property p_tx_status;
        @(posedge clock) disable iff (!rst_n)
        line_status[7:5] == {fifo_has_error, tsr_empty, thr_empty};
    endproperty
    a_tx_status: assert property (p_tx_status)
        else $error("transmit or fifo status bits wrong");
endmodule
`default_nettype wire

// *** test/umcls_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module umcls_partner
(
    input  wire logic dtr_n,
    input  wire logic rts_n,
    input  wire logic ring,
    input  wire logic spc,
    output logic      cts_n,
    output logic      dsr_n,
    output logic      ri_n,
    output logic      dcd_n,
    output logic      rxd
);
    // The remote end echoes our handshakes at once, as a null modem would.
    assign cts_n = rts_n;
    assign dsr_n = dtr_n;
    assign ri_n  = !ring;
    assign dcd_n = !ring;
    assign rxd   = !spc;
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    import umcls_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic        core_txd, txd, rxd, core_rxd, cts_n, dsr_n, ri_n, dcd_n;
    logic        dtr_n, rts_n, msr_cts, msr_dsr, msr_ri, msr_dcd, ring, spc;
    logic        nz, room_low, tx_allowed, diag_mode, half_stop, ferr, thre;
    logic        temt, rd_err;
    logic [3:0]  ev;
    int          miscompares, n_compared;
    umcls_top DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_txd(core_txd), .txd(txd), .rxd(rxd), .core_rxd(core_rxd),
        .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n),
        .dtr_n(dtr_n), .rts_n(rts_n), .msr_cts(msr_cts), .msr_dsr(msr_dsr),
        .msr_ri(msr_ri), .msr_dcd(msr_dcd), .rx_fifo_level_nz(nz),
        .rx_room_low(room_low), .tx_allowed(tx_allowed),
        .diag_mode(diag_mode), .half_stop(half_stop), .ev_overrun(ev[0]),
        .ev_parity(ev[1]), .ev_framing(ev[2]), .ev_break(ev[3]),
        .fifo_has_error(ferr), .thr_empty(thre), .tsr_empty(temt));
    umcls_partner far (.dtr_n(dtr_n), .rts_n(rts_n), .ring(ring),
        .spc(spc), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
        .dcd_n(dcd_n), .rxd(rxd));
    task automatic chk(input string nm, input logic [31:0] exp, got);
        n_compared++;
        if (exp !== got)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Read data is taken at the completing edge, before the clear-on-read
    // update of that same edge lands; outputs are checked at the negedge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock);
    endtask
    task automatic results;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial
    begin
        repeat (3000) @(posedge clock);
        miscompares++;
        results();
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, core_txd, ring, spc} = 7'h00;
        {nz, room_low, ev, ferr, thre, temt} = 9'h10E;
        paddr = 8'h00;
        pwdata = 32'h0;
        miscompares = 0;
        n_compared = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, UMCLS_OFF_MODEM_CTL, 32'h0);
        chk("mc_rst", 32'h0, rd_data);
        chk("pins_rst", 32'hE, {dtr_n, rts_n, diag_mode, half_stop});
        chk("diag", 32'h0, {txd, core_rxd});
        // The far end is taken to be a compatible device of the same type.
        apb(1'b1, UMCLS_OFF_MODEM_CTL, 32'hFFFFFFFF);
        apb(1'b0, UMCLS_OFF_MODEM_CTL, 32'h0);
        chk("mc_rw", 32'hBF, rd_data);
        chk("half", 32'h1, half_stop);
        apb(1'b1, UMCLS_OFF_MODEM_CTL, 32'h1C);
        chk("loop_a", 32'h3, {msr_cts, msr_dsr, msr_ri, msr_dcd});
        chk("loop_tx", 32'h2, {txd, core_rxd});
        @(posedge clock) ring <= 1'b1;
        apb(1'b1, UMCLS_OFF_MODEM_CTL, 32'h13);
        chk("loop_b", 32'hC, {msr_cts, msr_dsr, msr_ri, msr_dcd});
        apb(1'b1, UMCLS_OFF_MODEM_CTL, 32'h20);
        chk("cts_only", 32'h9, {rts_n, tx_allowed, diag_mode, core_rxd});
        apb(1'b1, UMCLS_OFF_MODEM_CTL, 32'h22);
        chk("auto_rts", 32'h1, {rts_n, tx_allowed});
        @(posedge clock) room_low <= 1'b1;
        @(negedge clock) chk("auto_stop", 32'h2, {rts_n, tx_allowed});
        apb(1'b1, UMCLS_OFF_MODEM_CTL, 32'h02);
        chk("afe_off", 32'h1, {rts_n, tx_allowed});
        apb(1'b1, UMCLS_OFF_MODEM_CTL, 32'h01);
        chk("dtr_rts", 32'h1, {dtr_n, rts_n});
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock) ev <= 4'h1 << i;
            @(posedge clock) ev <= 4'h0;
            apb(1'b0, UMCLS_OFF_LINE_STAT, 32'h0);
            chk("ls_err", 32'hA1 | (32'h2 << i), rd_data);
            apb(1'b0, UMCLS_OFF_LINE_STAT, 32'h0);
            chk("ls_clr", 32'hA1, rd_data);
        end
        @(posedge clock) {nz, thre, temt, ferr, core_txd} <= 5'h0D;
        apb(1'b0, UMCLS_OFF_LINE_STAT, 32'h0);
        chk("ls_flip", 32'h60, rd_data);
        apb(1'b1, UMCLS_OFF_LINE_STAT, 32'h05);
        chk("ls_wr", 32'h1, rd_err);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, rd_err);
        chk("tx_idle", 32'h1, txd);
        apb(1'b1, UMCLS_OFF_LINE_CTL, 32'h40);
        chk("brk", 32'h0, txd);
        results();
    end
endmodule
`default_nettype wire
